// >>> rtl/card_access_map.vh
// constants for the card access sequencer
`ifndef CARD_ACCESS_MAP_VH
`define CARD_ACCESS_MAP_VH
// address partition: bits 28:26 pick slot and space
`define PART_LSB        26
`define PART_SLOT_BIT   28
`define SPACE_IO        2'b00
`define SPACE_ATTR      2'b01
`define SPACE_RSVD      2'b10
`define SPACE_COMMON    2'b11
// access sizes
`define SIZE_BYTE       2'b00
`define SIZE_HALF       2'b01
`define SIZE_WORD       2'b10
// timing field layout inside expansion_timing_config (5 bits per field)
`define TV_WIDTH        5
`define TV_COM0_LSB     0
`define TV_IO0_LSB      5
`define TV_ATTR0_LSB    10
`define TV_COM1_LSB     16
`define TV_IO1_LSB      21
`define TV_ATTR1_LSB    26
// phase multipliers of (value+1)
`define SETUP_MULT      3'd3
`define CMD_MULT        3'd3
`define HOLD_MULT       3'd1
`define SAMPLE_MULT     3'd2
`endif

// >>> rtl/card_access_sequencer.v
// card expansion access sequencer: decode, lane steering, sizing and timing
//
// Overview of operation
// - drives one slot directly; socket_select output steers a second slot externally.
// - 32-bit host bus serving 8- and 16-bit cards in I/O space; memory spaces taken as 16-bit.
// - no card DMA; only processor-initiated memory, I/O and attribute transfers.
// - each access is timed by an internal clock set per address space.
// - address decodes into eight 64 Mbyte partitions, four per slot.
// - address, attribute select and socket select driven together at access start.
// - memory and attribute enables at address time; I/O enables after width known.
// - common memory uses memory strobes, always 16-bit, byte enables mark lanes.
// - I/O uses I/O strobes; width from sampled sixteen-bit-capable input.
// - I/O assumes 16-bit; without capable input, two low-lane bytes, A0=0 then 1.
// - word access to card space moves all 32 data lines at once; to an 8-bit I/O card it goes as two low-lane bytes.
// - aligned word to 16-bit space asserts both enables; others undefined.
// - even half-word to 16-bit space is one transfer with both enables.
// - even half-word to 8-bit space becomes two low-lane bytes, even first.
// - bytes on 8-bit space use low lane; on 16-bit, parity picks the lane.
// - timing value selected per slot and per space from separate fields.
// - phase lengths are cycles scaled by the timing value plus one.
`timescale 1ns/1ps
`default_nettype none
`include "card_access_map.vh"
module card_access_sequencer
#(
  parameter TW = 8
)
(
  input  wire        clk_i,
  input  wire        rst_i,
  // processor request side
  input  wire        req_valid_i,
  input  wire        req_write_i,
  input  wire [1:0]  req_size_i,
  input  wire [28:0] req_addr_i,
  input  wire [31:0] req_wdata_i,
  input  wire [31:0] expansion_timing_config_i,
  output reg         req_ready_o,
  output reg         resp_valid_o,
  output reg  [31:0] resp_rdata_o,
  // card side
  output reg  [25:0] card_addr_o,
  output reg         socket_select_o,
  output reg         attribute_space_select_n_o,
  output reg         low_byte_card_enable_n_o,
  output reg         high_byte_card_enable_n_o,
  output reg         card_mem_read_strobe_n_o,
  output reg         card_mem_write_strobe_n_o,
  output reg         card_io_read_strobe_n_o,
  output reg         card_io_write_strobe_n_o,
  input  wire        io_sixteen_bit_capable_n_i,
  input  wire [31:0] card_data_i,
  output reg  [31:0] card_data_o,
  output reg         card_data_oe_o
);
  localparam S_IDLE   = 3'd0;
  localparam S_SETUP  = 3'd1;
  localparam S_CMD    = 3'd2;
  localparam S_HOLD   = 3'd3;
  localparam S_DONE   = 3'd4;

  reg  [2:0]  state;
  reg         wr;
  reg  [1:0]  space;
  reg  [1:0]  size;
  reg  [31:0] wdata;
  reg  [31:0] rdata;
  reg  [4:0]  tv;
  reg         byte_split;   // doing two 8-bit transfers
  reg         second;       // second half of a split
  reg         width_known;
  reg         tmr_load;
  reg  [TW-1:0] tmr_count;
  wire        tmr_done;
  reg  [TW-1:0] sample_at;
  reg  [TW-1:0] cyc;
  wire        is_io = (space == `SPACE_IO);
  wire [1:0]  req_space = req_addr_i[`PART_LSB+1:`PART_LSB];
  wire        req_slot = req_addr_i[`PART_SLOT_BIT];

  // =====================================================
  // per slot, per space timing value selection
  function [4:0] pick_tv;
    input [31:0] cfg;
    input        slot;
    input [1:0]  sp;
    begin
      case ({slot, sp})
        {1'b0, `SPACE_COMMON}: pick_tv = cfg[`TV_COM0_LSB +: `TV_WIDTH];
        {1'b0, `SPACE_IO}:     pick_tv = cfg[`TV_IO0_LSB +: `TV_WIDTH];
        {1'b0, `SPACE_ATTR}:   pick_tv = cfg[`TV_ATTR0_LSB +: `TV_WIDTH];
        {1'b1, `SPACE_COMMON}: pick_tv = cfg[`TV_COM1_LSB +: `TV_WIDTH];
        {1'b1, `SPACE_IO}:     pick_tv = cfg[`TV_IO1_LSB +: `TV_WIDTH];
        {1'b1, `SPACE_ATTR}:   pick_tv = cfg[`TV_ATTR1_LSB +: `TV_WIDTH];
        default:               pick_tv = cfg[`TV_COM0_LSB +: `TV_WIDTH];
      endcase
    end
  endfunction

  // phase length = mult * (tv + 1), in processor cycles
  function [TW-1:0] scale;
    input [4:0] v;
    input [2:0] mult;
    begin
      scale = mult * ({{(TW-5){1'b0}}, v} + 1'b1);
    end
  endfunction

  phase_timer #(.WIDTH(TW)) u_timer
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  // =====================================================
  // access sequencer
  // reserved partitions are answered at once without touching the card
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                      <= S_IDLE;
      wr                         <= 1'b0;
      space                      <= 2'b00;
      size                       <= 2'b00;
      wdata                      <= 32'h00000000;
      rdata                      <= 32'h00000000;
      tv                         <= 5'h00;
      byte_split                 <= 1'b0;
      second                     <= 1'b0;
      width_known                <= 1'b0;
      tmr_load                   <= 1'b0;
      tmr_count                  <= {TW{1'b0}};
      sample_at                  <= {TW{1'b0}};
      cyc                        <= {TW{1'b0}};
      req_ready_o                <= 1'b1;
      resp_valid_o               <= 1'b0;
      resp_rdata_o               <= 32'h00000000;
      card_addr_o                <= 26'h0000000;
      socket_select_o            <= 1'b0;
      attribute_space_select_n_o <= 1'b1;
      low_byte_card_enable_n_o   <= 1'b1;
      high_byte_card_enable_n_o  <= 1'b1;
      card_mem_read_strobe_n_o   <= 1'b1;
      card_mem_write_strobe_n_o  <= 1'b1;
      card_io_read_strobe_n_o    <= 1'b1;
      card_io_write_strobe_n_o   <= 1'b1;
      card_data_o                <= 32'h00000000;
      card_data_oe_o             <= 1'b0;
    end
    else
    begin
      tmr_load     <= 1'b0;
      resp_valid_o <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (req_valid_i && req_ready_o)
          begin
            req_ready_o <= 1'b0;
            wr          <= req_write_i;
            space       <= req_space;
            size        <= req_size_i;
            wdata       <= req_wdata_i;
            rdata       <= 32'h00000000;
            second      <= 1'b0;
            byte_split  <= 1'b0;
            if (req_space == `SPACE_RSVD)
            begin
              resp_rdata_o <= 32'h00000000;
              state        <= S_DONE;
            end
            else
            begin
              tv <= pick_tv(expansion_timing_config_i, req_slot, req_space);
              // address, attribute and socket select change together
              card_addr_o                <= req_addr_i[25:0];
              socket_select_o            <= req_slot;
              attribute_space_select_n_o <= ~(req_space == `SPACE_ATTR);
              // a byte goes out on every lane so either enable finds it
              card_data_o                <= (req_size_i == `SIZE_BYTE) ?
                                            {4{req_wdata_i[7:0]}} : req_wdata_i;
              card_data_oe_o             <= req_write_i;
              width_known                <= (req_space != `SPACE_IO);
              // memory spaces are 16-bit: enables go out at address time
              if (req_space != `SPACE_IO)
              begin
                if (req_size_i == `SIZE_BYTE)
                begin
                  low_byte_card_enable_n_o  <= req_addr_i[0];
                  high_byte_card_enable_n_o <= ~req_addr_i[0];
                end
                else
                begin
                  low_byte_card_enable_n_o  <= 1'b0;
                  high_byte_card_enable_n_o <= 1'b0;
                end
              end
              tmr_count <= scale(pick_tv(expansion_timing_config_i, req_slot, req_space),
                                 `SETUP_MULT);
              sample_at <= scale(pick_tv(expansion_timing_config_i, req_slot, req_space),
                                 `SAMPLE_MULT) - 1'b1;
              cyc       <= {TW{1'b0}};
              tmr_load  <= 1'b1;
              state     <= S_SETUP;
            end
          end
        end
        S_SETUP:
        begin
          cyc <= cyc + 1'b1;
          // I/O width decided once at a fixed point inside setup
          if (is_io && !width_known && cyc == sample_at)
          begin
            width_known <= 1'b1;
            if (!io_sixteen_bit_capable_n_i)
            begin
              if (size == `SIZE_BYTE)
              begin
                low_byte_card_enable_n_o  <= card_addr_o[0];
                high_byte_card_enable_n_o <= ~card_addr_o[0];
              end
              else
              begin
                low_byte_card_enable_n_o  <= 1'b0;
                high_byte_card_enable_n_o <= 1'b0;
              end
            end
            else
            begin
              // 8-bit target: low lane only
              low_byte_card_enable_n_o  <= 1'b0;
              high_byte_card_enable_n_o <= 1'b1;
              if (size != `SIZE_BYTE)
              begin
                byte_split     <= 1'b1;
                card_addr_o[0] <= 1'b0;
              end
            end
          end
          if (tmr_done && !tmr_load && width_known)
          begin
            // strobe choice: memory spaces vs I/O
            card_mem_read_strobe_n_o  <= ~(!is_io && !wr);
            card_mem_write_strobe_n_o <= ~(!is_io && wr);
            card_io_read_strobe_n_o   <= ~(is_io && !wr);
            card_io_write_strobe_n_o  <= ~(is_io && wr);
            tmr_count <= scale(tv, `CMD_MULT);
            tmr_load  <= 1'b1;
            state     <= S_CMD;
          end
        end
        S_CMD:
        begin
          if (tmr_done && !tmr_load)
          begin
            card_mem_read_strobe_n_o  <= 1'b1;
            card_mem_write_strobe_n_o <= 1'b1;
            card_io_read_strobe_n_o   <= 1'b1;
            card_io_write_strobe_n_o  <= 1'b1;
            // capture read data with lane steering
            if (!wr)
            begin
              if (byte_split)
              begin
                if (second)
                  rdata[15:8] <= card_data_i[7:0];
                else
                  rdata[7:0]  <= card_data_i[7:0];
              end
              else if (size == `SIZE_BYTE)
                rdata <= {24'h000000, (high_byte_card_enable_n_o ?
                                       card_data_i[7:0] : card_data_i[15:8])};
              else if (size == `SIZE_HALF)
                rdata <= {16'h0000, card_data_i[15:0]};
              else
                rdata <= card_data_i;
            end
            tmr_count <= scale(tv, `HOLD_MULT);
            tmr_load  <= 1'b1;
            state     <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          if (tmr_done && !tmr_load)
          begin
            if (byte_split && !second)
            begin
              // odd byte follows on the low lane with address bit 0 set
              second         <= 1'b1;
              card_addr_o[0] <= 1'b1;
              card_data_o    <= {24'h000000, wdata[15:8]};
              tmr_count      <= scale(tv, `SETUP_MULT);
              tmr_load       <= 1'b1;
              state          <= S_SETUP;
            end
            else
            begin
              low_byte_card_enable_n_o   <= 1'b1;
              high_byte_card_enable_n_o  <= 1'b1;
              attribute_space_select_n_o <= 1'b1;
              card_data_oe_o             <= 1'b0;
              resp_rdata_o               <= rdata;
              state                      <= S_DONE;
            end
          end
        end
        S_DONE:
        begin
          resp_valid_o <= 1'b1;
          req_ready_o  <= 1'b1;
          state        <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> rtl/phase_timer.v
// down counter timing one access phase in processor clock cycles
`timescale 1ns/1ps
`default_nettype none
module phase_timer
#(
  parameter WIDTH = 8
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  output reg              done_o
);
  reg [WIDTH-1:0] remain;
  // =====================================================
  // counter
  // done is raised one edge early: the caller acts on it a cycle later,
  // so a phase lasts exactly count cycles; counts below two stretch to two
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remain <= {WIDTH{1'b0}};
      done_o <= 1'b0;
    end
    else if (load_i)
    begin
      remain <= (count_i > 2) ? count_i - 2'd2 : {WIDTH{1'b0}};
      done_o <= (count_i <= 2);
    end
    else if (remain > 1)
    begin
      remain <= remain - 1'b1;
      done_o <= 1'b0;
    end
    else
    begin
      remain <= {WIDTH{1'b0}};
      done_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> test/card_access_sequencer_sva.sv
// checker on the card access sequencer ports
`timescale 1ns/1ps
`default_nettype none
module card_access_sequencer_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire logic resp_valid_o,
  input wire logic socket_select_o,
  input wire logic attribute_space_select_n_o,
  input wire logic low_byte_card_enable_n_o,
  input wire logic high_byte_card_enable_n_o,
  input wire logic card_mem_read_strobe_n_o,
  input wire logic card_mem_write_strobe_n_o,
  input wire logic card_io_read_strobe_n_o,
  input wire logic card_io_write_strobe_n_o,
  input wire logic card_data_oe_o
);
  // ================================
  // command helpers
  wire [3:0] on  = ~{card_mem_read_strobe_n_o, card_mem_write_strobe_n_o,
                     card_io_read_strobe_n_o, card_io_write_strobe_n_o};
  wire       cmd = |on;
  wire       en  = !(low_byte_card_enable_n_o & high_byte_card_enable_n_o);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // idle bus must be fully released
  a_idle_quiet: assert property (req_ready_o |-> !cmd && !en)
    else $error("card driven while idle");
  a_one_command: assert property ($onehot0(on))
    else $error("two command strobes at once");
  a_command_enabled: assert property (cmd |-> en)
    else $error("command without card enable");
  // at least three cycles of command and of setup, since T is never below one
  a_command_min: assert property ($rose(cmd) |=> cmd [*2])
    else $error("command pulse too short");
  a_setup_min: assert property ($rose(cmd) |-> !$past(req_ready_o, 3))
    else $error("command too soon after request");
  a_select_steady: assert property (cmd && $past(cmd) |-> $stable(socket_select_o)
    && $stable(attribute_space_select_n_o))
    else $error("selects moved during command");
  a_enable_hold: assert property ($fell(cmd) |-> en)
    else $error("enables dropped with command");
  a_write_drive: assert property ((on[2] | on[0]) |-> card_data_oe_o)
    else $error("write without data drive");
  a_answer_pulse: assert property (resp_valid_o |-> req_ready_o ##1 !resp_valid_o)
    else $error("answer not a single pulse");
endmodule
bind card_access_sequencer card_access_sequencer_sva card_access_sequencer_sva_inst
(
  .clk_i, .rst_i, .req_ready_o, .resp_valid_o, .socket_select_o,
  .attribute_space_select_n_o, .low_byte_card_enable_n_o, .high_byte_card_enable_n_o,
  .card_mem_read_strobe_n_o, .card_mem_write_strobe_n_o, .card_io_read_strobe_n_o,
  .card_io_write_strobe_n_o, .card_data_oe_o
);
`default_nettype wire

// >>> test/card_access_sequencer_test.sv
// self-checking bench for the card access sequencer
`timescale 1ns/1ps
`default_nettype none
module card_access_sequencer_test;
  // ================================
  // pins and records
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        valid = 1'b0;
  logic        wr    = 1'b0;
  logic        wide  = 1'b1;
  logic [1:0]  size  = 2'h0;
  logic [28:0] addr  = 29'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] cfg   = 32'h00030820; // com0 0, io0 1, attr0 2, com1 3
  wire         ready, resp, sock, attr_n, lo_n, hi_n, mr_n, mw_n, ir_n, iw_n, cap_n, oe;
  wire  [31:0] rdata, cdi, cdo;
  wire  [25:0] ca;
  wire         cmd   = !(mr_n & mw_n & ir_n & iw_n);
  int          errors, checked, n;
  logic        was   = 1'b0;
  logic [3:0]  kd [4];
  logic [1:0]  en [4], sa [4];
  logic        a0 [4];
  logic [31:0] dq [4];
  int          ln [4];
  card_access_sequencer #(.TW(8)) card_access_sequencer_inst
  (
    .clk_i(clk), .rst_i(rst), .req_valid_i(valid), .req_write_i(wr), .req_size_i(size),
    .req_addr_i(addr), .req_wdata_i(wdata), .expansion_timing_config_i(cfg),
    .req_ready_o(ready), .resp_valid_o(resp), .resp_rdata_o(rdata), .card_addr_o(ca),
    .socket_select_o(sock), .attribute_space_select_n_o(attr_n),
    .low_byte_card_enable_n_o(lo_n), .high_byte_card_enable_n_o(hi_n),
    .card_mem_read_strobe_n_o(mr_n), .card_mem_write_strobe_n_o(mw_n),
    .card_io_read_strobe_n_o(ir_n), .card_io_write_strobe_n_o(iw_n),
    .io_sixteen_bit_capable_n_i(cap_n), .card_data_i(cdi), .card_data_o(cdo),
    .card_data_oe_o(oe)
  );
  card_slot_model card_slot_model_inst
  (
    .clk_i(clk), .wide_i(wide), .read_n_i(mr_n & ir_n), .lo_n_i(lo_n), .hi_n_i(hi_n),
    .addr_i(ca), .cap_n_o(cap_n), .data_o(cdi)
  );
  // 250 MHz clock
  always #2 clk = ~clk;
  // record each command pulse; sampled mid-cycle so outputs have settled
  always @(negedge clk)
  begin
    if (cmd && !was && n < 4)
    begin
      kd[n] = {mr_n, mw_n, ir_n, iw_n};
      en[n] = {hi_n, lo_n};
      sa[n] = {sock, attr_n};
      a0[n] = ca[0];
      dq[n] = cdo;
      ln[n] = 0;
      n++;
    end
    if (cmd && n > 0)
      ln[n-1]++;
    was = cmd;
  end
  function automatic logic [15:0] ex16(input logic [25:0] a);
    return 16'h5a3c ^ {a[15:1], 1'b0};
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one request held until taken, then a bounded wait for the answer
  task automatic acc(input logic w, input logic [1:0] s, input logic [28:0] a,
                     input logic [31:0] d, input logic wd);
    int i;
    @(posedge clk);
    #1;
    n = 0;
    i = 0;
    {wr, size, addr, wdata, wide, valid} = {w, s, a, d, wd, 1'b1};
    @(negedge clk);
    while (ready !== 1'b1 && i < 500)
    begin
      @(negedge clk);
      i++;
    end
    @(posedge clk);
    #1;
    valid = 1'b0;
    while (resp !== 1'b1 && i < 500)
    begin
      @(negedge clk);
      i++;
    end
    if (i >= 500)
    begin
      chk("answer", 1, 0);
      conclude();
    end
  endtask
  task automatic t_mem;
    acc(1'b0, 2'h1, 29'h0c001234, 32'h0, 1'b1);
    chk("pulses", 1, n);
    chk("kind", 4'h7, kd[0]);
    chk("lanes", 2'h0, en[0]);
    chk("selects", 2'h1, sa[0]);
    chk("length", 3, ln[0]);
    chk("half", ex16(26'h1234), rdata[15:0]);
    acc(1'b1, 2'h2, 29'h1c000100, 32'h8badf00d, 1'b1);
    chk("word lanes", 2'h0, en[0]);
    chk("word out", 32'h8badf00d, dq[0]);
    chk("slot", 2'h3, sa[0]);
    chk("scaled", 12, ln[0]);
    acc(1'b0, 2'h2, 29'h0c000100, 32'h0, 1'b1);
    chk("word in", {16'hc3a5 ^ ex16(26'h100), ex16(26'h100)}, rdata);
    $display("done common memory");
  endtask
  task automatic t_io;
    acc(1'b0, 2'h1, 29'h00000040, 32'h0, 1'b1);
    chk("io pulses", 1, n);
    chk("io kind", 4'hd, kd[0]);
    chk("io length", 6, ln[0]);
    chk("io half", ex16(26'h40), rdata[15:0]);
    acc(1'b1, 2'h1, 29'h00000042, 32'h0000a55a, 1'b0);
    chk("split pulses", 2, n);
    chk("split kind", 4'he, kd[1]);
    chk("split lanes", 4'ha, {en[0], en[1]});
    chk("split order", 2'h1, {a0[0], a0[1]});
    chk("split bytes", 16'h5aa5, {dq[0][7:0], dq[1][7:0]});
    acc(1'b0, 2'h1, 29'h00000042, 32'h0, 1'b0);
    chk("split read", ex16(26'h42), rdata[15:0]);
    acc(1'b1, 2'h0, 29'h00000043, 32'h0000003c, 1'b0);
    chk("odd lane", 2'h2, en[0]);
    chk("odd bit", 1'b1, a0[0]);
    chk("odd data", 8'h3c, dq[0][7:0]);
    $display("done io space");
  endtask
  task automatic t_attr;
    acc(1'b1, 2'h0, 29'h04000010, 32'h00000011, 1'b1);
    chk("even lane", 2'h2, en[0]);
    chk("attr select", 2'h0, sa[0]);
    chk("attr length", 9, ln[0]);
    chk("even data", 8'h11, dq[0][7:0]);
    acc(1'b1, 2'h0, 29'h04000011, 32'h00000022, 1'b1);
    chk("high lane", 2'h1, en[0]);
    chk("high data", 8'h22, dq[0][15:8]);
    acc(1'b0, 2'h0, 29'h04000011, 32'h0, 1'b1);
    chk("high read", ex16(26'h11) >> 8, rdata);
    $display("done attribute space");
  endtask
  task automatic t_rsvd;
    acc(1'b0, 2'h1, 29'h08000000, 32'h0, 1'b1);
    chk("reserved pulses", 0, n);
    chk("reserved data", 32'h0, rdata);
    $display("done reserved space");
  endtask
  // reset, then every scenario in turn
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_mem();
    t_io();
    t_attr();
    t_rsvd();
    conclude();
  end
endmodule
`default_nettype wire

// >>> test/card_slot_model.sv
// behavioural card sitting in the slot
`timescale 1ns/1ps
`default_nettype none
module card_slot_model
(
  input  wire logic        clk_i,
  input  wire logic        wide_i,
  input  wire logic        read_n_i,
  input  wire logic        lo_n_i,
  input  wire logic        hi_n_i,
  input  wire logic [25:0] addr_i,
  output logic             cap_n_o,
  output logic [31:0]      data_o
);
  // ================================
  // card answer
  logic [31:0] idle = 32'h0;
  wire  [15:0] h    = 16'h5a3c ^ {addr_i[15:1], 1'b0};
  wire         odd  = !lo_n_i && hi_n_i && addr_i[0];
  // released bus toggles so a stale value never matches
  always @(posedge clk_i)
  begin
    idle <= ~idle;
  end
  // pulled up unless the card claims sixteen bits
  assign cap_n_o = !wide_i;
  // upper lane ignores bit 0; low lane alone picks the byte by it
  assign data_o = read_n_i ? idle : {16'hc3a5 ^ h, odd ? {2{h[15:8]}} : h};
endmodule
`default_nettype wire
